/* core/eag_cfg.svh */
// Purpose: constants for the effective address generator
// Assumes: 32-bit registers on an AHB-Lite slave, byte addresses are offsets
// Notes: offsets, fields, reset values and limits
`ifndef EAG_CFG_SVH
`define EAG_CFG_SVH

`define EAG_OFF_CTRL 12'h000
`define EAG_OFF_BASE_BX 12'h004
`define EAG_OFF_INDEX_BX 12'h008
`define EAG_OFF_DISP 12'h00C
`define EAG_OFF_SEGBASE0 12'h010
`define EAG_OFF_SELECTOR0 12'h028
`define EAG_OFF_REQ 12'h040
`define EAG_OFF_STATUS 12'h044
`define EAG_OFF_LINEAR 12'h048
`define EAG_OFF_PHYS 12'h04C
`define EAG_OFF_EA 12'h050
`define EAG_OFF_BFLAST 12'h054
`define EAG_OFF_GPR0 12'h060

// control register fields
`define EAG_CTRL_PROT 0
`define EAG_CTRL_DBIT 1
`define EAG_CTRL_PAGING 2
`define EAG_CTRL_RESET 32'h0000_0000

// request register fields
`define EAG_REQ_KIND_LSB 0
`define EAG_REQ_BASE_LSB 4
`define EAG_REQ_INDEX_LSB 8
`define EAG_REQ_SCALE_LSB 12
`define EAG_REQ_DISPW_LSB 14
`define EAG_REQ_HAS_BASE 16
`define EAG_REQ_HAS_INDEX 17
`define EAG_REQ_OVR_EN 18
`define EAG_REQ_OVR_LSB 19
`define EAG_REQ_OPSZ_PFX 22
`define EAG_REQ_ADSZ_PFX 23
`define EAG_REQ_PORT_IMM 24
`define EAG_REQ_PORT8_LSB 0

// status register fields
`define EAG_ST_BUSY 0
`define EAG_ST_DONE 1
`define EAG_ST_GPF 2
`define EAG_ST_ADDR32 3
`define EAG_ST_OP32 4
`define EAG_ST_MIO 5
`define EAG_ST_RSV 6
`define EAG_ST_SEG_LSB 8

`define EAG_REAL_LIMIT 32'h0000_FFFF
`define EAG_PHYS_MASK 32'h00FF_FFFF
`define EAG_PORT_MASK 32'h0000_FFFF
`define EAG_RSV_PORT_LO 16'h00F8
`define EAG_RSV_PORT_HI 16'h00FF
`define EAG_BITFIELD_MAX_BYTES 3'h4
`define EAG_STACK_REG 3'h4
`define EAG_FRAME_REG 3'h5

`endif

/* core/eag_pkg.sv */
// Purpose: types for the effective address generator
// Assumes: nothing beyond the cfg header
// Notes: segment codes follow the usual encoding order
package eag_pkg;

  typedef enum logic [2:0] {
    EAG_SEG_EXTRA = 3'h0,
    EAG_SEG_CODE = 3'h1,
    EAG_SEG_STACK = 3'h2,
    EAG_SEG_DATA = 3'h3,
    EAG_SEG_AUX1 = 3'h4,
    EAG_SEG_AUX2 = 3'h5
  } eag_seg_t;

  typedef enum logic [3:0] {
    EAG_REF_DATA = 4'h0,
    EAG_REF_CODE = 4'h1,
    EAG_REF_PUSH = 4'h2,
    EAG_REF_POP = 4'h3,
    EAG_REF_STR_DST = 4'h4,
    EAG_REF_IO = 4'h5
  } eag_ref_t;

  typedef enum logic [1:0] {
    EAG_ST_IDLE = 2'b00,
    EAG_ST_EXTRA = 2'b01,
    EAG_ST_DONE = 2'b11
  } eag_state_t;

endpackage : eag_pkg

/* core/eag_core.sv */
// Purpose: effective address generator with an AHB-Lite register port
// Assumes: one 40 MHz clock, single word transfers, response always OKAY
// Notes: software loads registers, writes the request word, polls status
// Operation
// - push, push-flags, int, call, push-all write via stack_segment, no override
// - pop, pop-all, pop-flags, iret, ret read via stack_segment, no override
// - string destination uses extra_segment; code fetch uses code segment
// - other data default data_segment, frame or stack base gives stack segment
// - linear address is segment base plus effective address
// - displacement is an 8, 16 or 32-bit immediate field
// - 32-bit index excludes stack_pointer_reg, scaled by 1, 2, 4 or 8
// - no extra cycles except one extra clock when base and index both used; a base with stack_pointer_reg as 32-bit index also gets the extra clock
// - six memory modes from displacement, base and scaled index combinations
// - code segment size bit 0 gives 16-bit defaults, 1 gives 32-bit
// - real mode defaults are 16-bit operand and address size
// - operand and address length prefixes each invert their default, independently
// - real mode offset above 0FFFFH raises general protection fault
// - 16-bit: base base_word_reg/frame_word_reg, index source/target_word_reg, no scale
// - 32-bit: displacement 0, 8 or 32 bits, any base, index not stack pointer
// - I/O space spans 64K byte addresses, 8 or 16-bit ports
// - port addresses bypass segmentation and paging
// - port address from 8-bit immediate or port_pointer_reg, zero extended
// - I/O cycles drive memory_or_port_select low
// - bit fields cover up to 32 bits, span at most four bytes
// - real mode linear address is selector shifted left four plus offset
// - without paging the physical address is the low 24 linear bits
`timescale 1ns/1ps
`include "eag_cfg.svh"

module eag_core (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // result toward the bus interface unit
  output logic [23:0] phys_addr_o,
  output logic memory_or_port_select_o,
  output logic addr_valid_o,
  output logic gp_fault_o
);

  typedef struct packed {
    logic ph_wr;
    logic ph_rd;
    logic [11:0] ph_addr;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [31:0] disp;
    logic [31:0] req;
    logic [5:0][31:0] seg_base;
    logic [5:0][15:0] seg_sel;
    logic [7:0][31:0] gpr;
    eag_pkg::eag_state_t state;
    logic [31:0] ea;
    logic [31:0] linear;
    logic [23:0] phys;
    logic mio;
    logic gpf;
    logic addr32;
    logic op32;
    eag_pkg::eag_seg_t seg;
    logic [31:0] bf_last;
    logic rsv;
    logic valid;
  } eag_regs_t;

  eag_regs_t r;
  eag_regs_t next_r;

  // combinational address path for the request held in r.req
  eag_pkg::eag_ref_t kind;
  logic [2:0] base_sel;
  logic [2:0] index_sel;
  logic [1:0] scale;
  logic [1:0] disp_w;
  logic has_base;
  logic has_index;
  logic d_addr32;
  logic d_op32;
  logic [31:0] base_v;
  logic [31:0] index_v;
  logic [31:0] disp_v;
  logic [31:0] ea_sum;
  logic [31:0] port_addr;
  eag_pkg::eag_seg_t seg_pick;
  logic [31:0] seg_lin;
  logic [31:0] lin;
  logic gpf_c;
  logic [31:0] bf_end;

  always_comb begin
    kind = eag_pkg::eag_ref_t'(r.req[`EAG_REQ_KIND_LSB +: 4]);
    base_sel = r.req[`EAG_REQ_BASE_LSB +: 3];
    index_sel = r.req[`EAG_REQ_INDEX_LSB +: 3];
    scale = r.req[`EAG_REQ_SCALE_LSB +: 2];
    disp_w = r.req[`EAG_REQ_DISPW_LSB +: 2];
    has_base = r.req[`EAG_REQ_HAS_BASE];
    has_index = r.req[`EAG_REQ_HAS_INDEX];
    // real mode forces 16-bit defaults, else the code segment size bit
    d_addr32 = r.ctrl[`EAG_CTRL_PROT] & r.ctrl[`EAG_CTRL_DBIT];
    d_op32 = d_addr32;
    d_addr32 = d_addr32 ^ r.req[`EAG_REQ_ADSZ_PFX];
    d_op32 = d_op32 ^ r.req[`EAG_REQ_OPSZ_PFX];
    // displacement widths: 0, 8, 16 (16-bit) or 32 (32-bit), sign extended
    unique case (disp_w)
      2'h0: disp_v = 32'h0000_0000;
      2'h1: disp_v = {{24{r.disp[7]}}, r.disp[7:0]};
      default: disp_v = d_addr32 ? r.disp : {{16{r.disp[15]}}, r.disp[15:0]};
    endcase
    if (d_addr32) begin
      base_v = has_base ? r.gpr[base_sel] : 32'h0000_0000;
      // stack pointer as index encodes no index
      index_v = (has_index && index_sel != `EAG_STACK_REG) ?
                (r.gpr[index_sel] << scale) : 32'h0000_0000;
    end else begin
      // base: 0 selects base_word_reg, 1 frame_word_reg; index: 0 source, 1 target
      base_v = !has_base ? 32'h0000_0000 :
               {16'h0000, r.gpr[base_sel[0] ? 3'h5 : 3'h3][15:0]};
      index_v = !has_index ? 32'h0000_0000 :
                {16'h0000, r.gpr[index_sel[0] ? 3'h7 : 3'h6][15:0]};
    end
    ea_sum = base_v + index_v + disp_v;
    if (!d_addr32) begin
      ea_sum = {16'h0000, ea_sum[15:0]};
    end
    // default segment choice and overrides
    unique case (kind)
      eag_pkg::EAG_REF_CODE: seg_pick = eag_pkg::EAG_SEG_CODE;
      eag_pkg::EAG_REF_PUSH: seg_pick = eag_pkg::EAG_SEG_STACK;
      eag_pkg::EAG_REF_POP: seg_pick = eag_pkg::EAG_SEG_STACK;
      eag_pkg::EAG_REF_STR_DST: seg_pick = eag_pkg::EAG_SEG_EXTRA;
      default: begin
        if (has_base && (d_addr32 ? (base_sel == `EAG_FRAME_REG || base_sel == `EAG_STACK_REG)
                                  : base_sel[0])) begin
          seg_pick = eag_pkg::EAG_SEG_STACK;
        end else begin
          seg_pick = eag_pkg::EAG_SEG_DATA;
        end
        if (r.req[`EAG_REQ_OVR_EN] && r.req[`EAG_REQ_OVR_LSB +: 3] <= 3'h5) begin
          seg_pick = eag_pkg::eag_seg_t'(r.req[`EAG_REQ_OVR_LSB +: 3]);
        end
      end
    endcase
    if (r.ctrl[`EAG_CTRL_PROT]) begin
      seg_lin = r.seg_base[seg_pick];
    end else begin
      seg_lin = {12'h000, r.seg_sel[seg_pick], 4'h0};
    end
    lin = seg_lin + ea_sum;
    // real mode limit check, also under a 32-bit address prefix
    gpf_c = !r.ctrl[`EAG_CTRL_PROT] && (ea_sum > `EAG_REAL_LIMIT);
    // a bit field is fetched as one window of at most four bytes from its offset
    bf_end = ea_sum + 32'(`EAG_BITFIELD_MAX_BYTES) - 32'h0000_0001;
    if (!d_addr32) begin
      // the window end wraps with the offset in 16-bit addressing
      bf_end = {16'h0000, bf_end[15:0]};
    end
    // port addresses: immediate 8 bits or port_pointer_reg, zero extended
    port_addr = r.req[`EAG_REQ_PORT_IMM] ?
                {24'h000000, r.req[`EAG_REQ_PORT8_LSB +: 8]} :
                {16'h0000, r.gpr[2][15:0]};
  end

  logic [5:0] seg_base_hit;
  logic [5:0] seg_sel_hit;
  logic [7:0] gpr_hit;

  // per-entry offset decode, shared by the read mux and the write path
  for (genvar g = 0; g < 8; g++) begin : g_entry_dec
    assign gpr_hit[g] = (r.ph_addr == `EAG_OFF_GPR0 + 12'(4 * g));
    if (g < 6) begin : g_seg_dec
      assign seg_base_hit[g] = (r.ph_addr == `EAG_OFF_SEGBASE0 + 12'(4 * g));
      assign seg_sel_hit[g] = (r.ph_addr == `EAG_OFF_SELECTOR0 + 12'(4 * g));
    end
  end

  logic [11:0] rd_off;
  logic [31:0] rd_mux;
  logic [31:0] status_w;

  // reads are registered on the data phase edge, hence one wait state per read
  always_comb begin
    rd_off = r.ph_addr;
    // status holds the last finished request, except busy and done, which follow the live state and valid
    status_w = 32'h0000_0000;
    status_w[`EAG_ST_BUSY] = (r.state != eag_pkg::EAG_ST_IDLE);
    status_w[`EAG_ST_DONE] = r.valid;
    status_w[`EAG_ST_GPF] = r.gpf;
    status_w[`EAG_ST_ADDR32] = r.addr32;
    status_w[`EAG_ST_OP32] = r.op32;
    status_w[`EAG_ST_MIO] = r.mio;
    status_w[`EAG_ST_RSV] = r.rsv;
    status_w[`EAG_ST_SEG_LSB +: 3] = r.seg;
    rd_mux = 32'h0000_0000;
    if (rd_off == `EAG_OFF_CTRL) rd_mux = r.ctrl;
    else if (rd_off == `EAG_OFF_DISP) rd_mux = r.disp;
    else if (rd_off == `EAG_OFF_REQ) rd_mux = r.req;
    else if (rd_off == `EAG_OFF_STATUS) rd_mux = status_w;
    else if (rd_off == `EAG_OFF_LINEAR) rd_mux = r.linear;
    else if (rd_off == `EAG_OFF_PHYS) rd_mux = {8'h00, r.phys};
    else if (rd_off == `EAG_OFF_EA) rd_mux = r.ea;
    else if (rd_off == `EAG_OFF_BFLAST) rd_mux = r.bf_last;
    for (int i = 0; i < 6; i++) begin
      if (seg_base_hit[i]) begin
        rd_mux = r.seg_base[i];
      end
      if (seg_sel_hit[i]) begin
        rd_mux = {16'h0000, r.seg_sel[i]};
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (gpr_hit[i]) begin
        rd_mux = r.gpr[i];
      end
    end
  end

  // a request word write in the idle state starts the sequence
  logic start;
  logic two_part;

  always_comb begin
    next_r = r;
    start = 1'b0;
    // base plus index costs one more adder pass; port requests use no adder
    two_part = hwdata_i[`EAG_REQ_HAS_BASE] && hwdata_i[`EAG_REQ_HAS_INDEX] &&
               (eag_pkg::eag_ref_t'(hwdata_i[`EAG_REQ_KIND_LSB +: 4]) !=
                eag_pkg::EAG_REF_IO);
    // address phase capture
    next_r.ph_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    next_r.ph_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_r.ph_addr = {haddr_i[11:2], 2'b00};
    end
    if (r.ph_rd) begin
      next_r.rdata = rd_mux;
    end
    if (r.ph_wr) begin
      // write data arrives one edge after its address phase
      if (r.ph_addr == `EAG_OFF_CTRL) begin
        next_r.ctrl = hwdata_i;
      end
      if (r.ph_addr == `EAG_OFF_DISP) begin
        next_r.disp = hwdata_i;
      end
      if (r.ph_addr == `EAG_OFF_REQ) begin
        next_r.req = hwdata_i;
        start = 1'b1;
      end
      for (int i = 0; i < 6; i++) begin
        if (seg_base_hit[i]) begin
          next_r.seg_base[i] = hwdata_i;
        end
        if (seg_sel_hit[i]) begin
          next_r.seg_sel[i] = hwdata_i[15:0];
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (gpr_hit[i]) begin
          next_r.gpr[i] = hwdata_i;
        end
      end
    end
    // request sequencing: result one cycle after the request, two with base and index
    unique case (r.state)
      eag_pkg::EAG_ST_IDLE: begin
        if (start) begin
          next_r.valid = 1'b0;
          next_r.state = eag_pkg::EAG_ST_DONE;
          if (two_part) begin
            next_r.state = eag_pkg::EAG_ST_EXTRA;
          end
        end
      end
      eag_pkg::EAG_ST_EXTRA: next_r.state = eag_pkg::EAG_ST_DONE;
      eag_pkg::EAG_ST_DONE: begin
        next_r.state = eag_pkg::EAG_ST_IDLE;
        next_r.valid = 1'b1;
        next_r.addr32 = d_addr32;
        next_r.op32 = d_op32;
        if (kind == eag_pkg::EAG_REF_IO) begin
          next_r.ea = port_addr;
          next_r.linear = port_addr;
          next_r.phys = port_addr[23:0];
          next_r.mio = 1'b0;
          next_r.gpf = 1'b0;
          next_r.seg = eag_pkg::EAG_SEG_DATA;
          // no bit field lives in port space
          next_r.bf_last = 32'h0000_0000;
          // flag ports in the window kept free of system peripherals
          next_r.rsv = (port_addr[15:0] >= `EAG_RSV_PORT_LO) &&
                       (port_addr[15:0] <= `EAG_RSV_PORT_HI);
        end else begin
          next_r.ea = ea_sum;
          next_r.linear = lin;
          // paging is not modelled here; the low 24 bits pass either way
          next_r.phys = lin[23:0];
          next_r.mio = 1'b1;
          next_r.gpf = gpf_c;
          next_r.seg = seg_pick;
          next_r.bf_last = bf_end;
          next_r.rsv = 1'b0;
        end
      end
      default: next_r.state = eag_pkg::EAG_ST_IDLE;
    endcase
  end

  // clock enable low holds every register, bus capture included
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // memory select idles high so no port cycle shows before a result
      r <= '0;
      r.mio <= 1'b1;
      r.seg <= eag_pkg::EAG_SEG_DATA;
      r.state <= eag_pkg::EAG_ST_IDLE;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  assign hrdata_o = r.rdata;
  // read data is registered, so a read holds the data phase one cycle
  assign hreadyout_o = !(r.ph_rd);
  assign hresp_o = 1'b0;
  assign phys_addr_o = r.phys;
  assign memory_or_port_select_o = r.mio;
  assign addr_valid_o = r.valid;
  assign gp_fault_o = r.gpf;

endmodule : eag_core

/* verification/eag_checker.sv */
// Purpose: port assertions for the effective address generator
// Assumes: one clock domain, async active-low reset, clock enable held high
// Notes: bound to eag_core below
`timescale 1ns/1ps
`include "eag_cfg.svh"
module eag_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // register bus
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // result
  input wire logic [23:0] phys_addr_o,
  input wire logic memory_or_port_select_o,
  input wire logic addr_valid_o
);
  logic req_dp;
  logic ap;
  assign ap = hsel_i & hready_i & htrans_i[1];
  // high during the data phase of a request word write
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) req_dp <= 1'b0;
    else req_dp <= ap & hwrite_i & (haddr_i == `EAG_OFF_REQ);
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_okay; hresp_o == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_wr_zero_wait; ap && hwrite_i |=> hreadyout_o; endproperty
  a_wr_zero_wait: assert property (p_wr_zero_wait) else $error("write stalled");
  property p_rd_one_wait; ap && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_rd_one_wait: assert property (p_rd_one_wait) else $error("read wait not one cycle");
  property p_req_latency; req_dp |=> !addr_valid_o ##[1:2] addr_valid_o; endproperty
  a_req_latency: assert property (p_req_latency) else $error("result latency wrong");
  property p_valid_cause; $rose(addr_valid_o) |-> $past(req_dp, 2) || $past(req_dp, 3); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("result without request");
  property p_io_zero_ext; addr_valid_o && !memory_or_port_select_o |-> phys_addr_o[23:16] == 8'h00;
  endproperty
  a_io_zero_ext: assert property (p_io_zero_ext) else $error("port address not zero extended");
  property p_result_hold;
    addr_valid_o && $past(addr_valid_o) |-> $stable(phys_addr_o) && $stable(memory_or_port_select_o);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved while valid");
  property p_valid_keep; addr_valid_o && !req_dp |=> addr_valid_o; endproperty
  a_valid_keep: assert property (p_valid_keep) else $error("valid dropped without request");
endmodule : eag_checker

bind eag_core eag_checker u_chk (.ref_clk_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hready_i, .hreadyout_o, .hresp_o, .phys_addr_o, .memory_or_port_select_o, .addr_valid_o);

/* verification/eag_biu_model.sv */
// Purpose: bus interface unit stand-in that runs one bus cycle per result
// Assumes: a result is new when the valid level rises
// Notes: peripherals decode every port outside the reserved range
`timescale 1ns/1ps
module eag_biu_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // result from the generator
  input wire logic [23:0] phys_addr_i,
  input wire logic mio_i,
  input wire logic valid_i,
  // cycle counts
  output logic [15:0] mem_cnt_o,
  output logic [15:0] io_cnt_o
);
  logic valid_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_q <= 1'b0;
      mem_cnt_o <= 16'h0000;
      io_cnt_o <= 16'h0000;
    end else begin
      valid_q <= valid_i;
      if (valid_i && !valid_q) begin
        if (mio_i) mem_cnt_o <= mem_cnt_o + 16'h0001;
        else if (phys_addr_i[15:0] < 16'h00F8 || phys_addr_i[15:0] > 16'h00FF)
          io_cnt_o <= io_cnt_o + 16'h0001;
      end
    end
  end
endmodule : eag_biu_model

/* verification/effective_address_generator_tb.sv */
// Purpose: self-checking bench for the effective address generator
// Assumes: registers reached over AHB-Lite, result polled on the valid level
// Notes: a behavioural model predicts address, pins, status and latency
`timescale 1ns/1ps
module effective_address_generator_tb;
  logic ref_clk_i, rst_b_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, mio, valid, gpf;
  logic [11:0] haddr_i;
  logic [1:0] htrans_i;
  logic [31:0] hwdata_i, hrdata_o, rd, ctrl, disp, q;
  logic [23:0] phys;
  logic [15:0] mem_cnt, io_cnt;
  logic [31:0] gpr [8];
  logic [31:0] sb [6];
  logic [31:0] sel [6];
  int n_fail, total_checks, exp_mem, exp_io, i;
  eag_core DUT (.ref_clk_i, .rst_b_i, .clk_en_i(1'b1), .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .phys_addr_o(phys), .memory_or_port_select_o(mio), .addr_valid_o(valid), .gp_fault_o(gpf));
  eag_biu_model u_biu (.ref_clk_i, .rst_b_i, .phys_addr_i(phys), .mio_i(mio), .valid_i(valid),
    .mem_cnt_o(mem_cnt), .io_cnt_o(io_cnt));
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_w
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge ref_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i <= a;
    hwrite_i <= wr;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus
  task run(input logic [31:0] r);
    logic rm, a32, o32, io, f, rv;
    logic [2:0] sg;
    logic [31:0] b, x, d, ea, lin, st, pt, mk;
    int k;
    io = r[3:0] == 4'h5;
    rm = !ctrl[0];
    a32 = (!rm & ctrl[1]) ^ r[23];
    o32 = (!rm & ctrl[1]) ^ r[22];
    b = !r[16] ? 0 : a32 ? gpr[r[6:4]] : gpr[r[4] ? 5 : 3] & 32'hFFFF;
    x = !r[17] ? 0 : a32 ? (r[10:8] == 3'h4 ? 0 : gpr[r[10:8]] << r[13:12]) : gpr[r[8] ? 7 : 6] & 32'hFFFF;
    d = r[15:14] == 2'h0 ? 0 : r[15:14] == 2'h1 ? disp & 32'hFF : a32 ? disp : disp & 32'hFFFF;
    ea = a32 ? b + x + d : (b + x + d) & 32'hFFFF;
    case (r[3:0])
      4'h1: sg = 3'h1;
      4'h2, 4'h3: sg = 3'h2;
      4'h4: sg = 3'h0;
      default: sg = (r[16] && (a32 ? r[6:5] == 2'h2 : r[4])) ? 3'h2 : 3'h3;
    endcase
    if (r[3:0] == 4'h0 && r[18] && r[21:19] <= 3'h5) sg = r[21:19];
    lin = rm ? {sel[sg][15:0], 4'h0} + ea : sb[sg] + ea;
    pt = r[24] ? {24'h0, r[7:0]} : gpr[2] & 32'hFFFF;
    f = rm && !io && ea > 32'hFFFF;
    rv = io && pt >= 32'hF8 && pt <= 32'hFF;
    st = {21'h0, sg, 1'b0, rv, ~io, o32, a32, f, 2'h0};
    mk = io ? 32'h60 : 32'h75C;
    bus(1'b1, 12'h040, r);
    @(posedge ref_clk_i);
    for (k = 0; k < 8 && valid !== 1'b1; k++) @(posedge ref_clk_i);
    // k starts one edge after the request is taken, so a plain request counts one
    if (!(a32 && r[10:8] == 3'h4)) chk_w(32'(k), 32'(1 + (r[16] & r[17] & !io)), "latency");
    if (!f) chk_w({8'h0, phys}, io ? pt : {8'h0, lin[23:0]}, "address");
    chk_w({30'h0, mio, gpf}, {30'h0, ~io, f}, "pins");
    if (io) exp_io += (pt < 32'hF8 || pt > 32'hFF);
    else exp_mem++;
    bus(1'b0, 12'h044, 32'h0);
    chk_w(rd & mk, st & mk, "status");
    bus(1'b0, 12'h054, 32'h0);
    chk_w(rd, io ? 32'h0 : a32 ? ea + 32'h3 : (ea + 32'h3) & 32'hFFFF, "bit field end");
  endtask : run
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #1250000;
    n_fail++;
    close_out;
  end
  initial begin
    {n_fail, total_checks, exp_mem, exp_io} = '0;
    {rst_b_i, hsel_i, hwrite_i, haddr_i, htrans_i, hwdata_i, ctrl} = '0;
    void'($urandom(95476));
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    chk_w({5'h0, phys, mio, valid, gpf}, 32'h4, "reset");
    for (i = 0; i < 8; i++) begin
      gpr[i] = $urandom();
      bus(1'b1, 12'h060 + 12'(i * 4), gpr[i]);
    end
    for (i = 0; i < 6; i++) begin
      sb[i] = $urandom();
      sel[i] = $urandom() & 32'hFFFF;
      bus(1'b1, 12'h010 + 12'(i * 4), sb[i]);
      bus(1'b1, 12'h028 + 12'(i * 4), sel[i]);
    end
    disp = $urandom() & 32'hFFFF7F7F;
    bus(1'b1, 12'h00C, disp);
    bus(1'b1, 12'h004, $urandom());
    bus(1'b0, 12'h004, 32'h0);
    chk_w(rd, 32'h0, "unmapped");
    for (i = 0; i < 200; i++) begin
      if (i % 20 == 0) begin
        ctrl = $urandom_range(0, 3);
        bus(1'b1, 12'h000, ctrl);
      end
      q = ($urandom() & 32'h01FF_FFF0) | $urandom_range(0, 5);
      run(q);
    end
    gpr[2] = 32'hABCD_00F8;
    bus(1'b1, 12'h068, gpr[2]);
    run(32'h0000_0005);
    run(32'h0100_00F5);
    repeat (2) @(posedge ref_clk_i);
    chk_w({16'h0, mem_cnt}, 32'(exp_mem), "memory cycles");
    chk_w({16'h0, io_cnt}, 32'(exp_io), "port cycles");
    close_out;
  end
endmodule : effective_address_generator_tb
